// ### ima_cell_rate_clock_gen.sv
// Top of the per-group cell-rate clock generator with its register port
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/10ps

module ima_cell_rate_clock_gen (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [cellclk_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Clock sources
  input wire logic external_timing_reference_in,
  input wire logic [cellclk_pkg::NUM_SERIAL-1:0] serial_receive_clock,
  input wire logic [cellclk_pkg::NUM_PORTS-1:0] line_side_cell_available,
  // Cell-rate clocks to the engine
  output logic [cellclk_pkg::NUM_GROUPS-1:0] transmit_cell_rate_clock,
  output logic [cellclk_pkg::NUM_GROUPS-1:0] receive_cell_rate_clock,
  // Timing references and line-side clocks
  output logic [cellclk_pkg::NUM_TREF-1:0] timing_reference_output,
  output logic line_side_receive_clock,
  output logic line_side_transmit_clock
);
  import cellclk_pkg::*;

  // ==========================================================================
  // Helpers
  function automatic logic chan_hit(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:9] == 3'h0;
  endfunction

  function automatic logic pick_event(input clk_src_t s, input logic t24, input logic pe,
                                      input logic [NUM_SERIAL-1:0] ser, input logic [2:0] idx,
                                      input logic t16);
    logic r;
    r = 1'b0;
    unique case (s)
      SRC_SYS24: r = t24;
      SRC_PRESCALE: r = pe;
      SRC_SERIAL: r = ser[idx];
      SRC_CELLAV: r = t16;
    endcase
    return r;
  endfunction

  logic [3:0] div16_cnt;
  logic [4:0] div24_cnt;
  logic tick16;
  logic tick24;
  logic [NUM_SERIAL:0] edge_prev;
  logic [NUM_SERIAL:0] edge_pend;
  logic [NUM_SERIAL:0] ext_event;
  logic [NUM_SERIAL:0] ext_rise;
  logic [NUM_PORTS-1:0] cav_prev;
  logic [NUM_PORTS-1:0] cav_rise;
  logic [31:0] chan_cfg [NUM_CHANS];
  logic [31:0] chan_inc [NUM_CHANS];
  logic [31:0] chan_div [NUM_CHANS];
  logic [15:0] pre_num;
  logic [15:0] pre_den;
  logic pre_src;
  logic [15:0] pre_acc;
  logic pre_pend;
  logic pre_event;
  logic [16:0] pre_sum;
  logic pre_in;
  logic [3:0] tref_cfg;
  logic [31:0] tref_div;
  logic [15:0] tref_cnt [NUM_TREF];
  logic [NUM_TREF-1:0] tref_gen;
  logic [NUM_CHANS-1:0] cell_ticks;
  logic [NUM_CHANS-1:0] status_flags;
  logic status_rd;
  logic [4:0] ch_idx;

  // ==========================================================================
  // System clock dividers
  // divide by 16 and by 24
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div16_cnt <= 4'h0;
      div24_cnt <= 5'h00;
      tick16 <= 1'b0;
      tick24 <= 1'b0;
    end
    else
    begin
      div16_cnt <= div16_cnt + 4'h1;
      tick16 <= (div16_cnt == DIV16_LAST);
      div24_cnt <= (div24_cnt == DIV24_LAST) ? 5'h00 : div24_cnt + 5'h01;
      tick24 <= (div24_cnt == DIV24_LAST);
    end
  end

  // line-side clocks are the system clock halved
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      line_side_receive_clock <= 1'b0;
      line_side_transmit_clock <= 1'b0;
    end
    else
    begin
      line_side_receive_clock <= ~line_side_receive_clock;
      line_side_transmit_clock <= ~line_side_transmit_clock;
    end
  end

  // ==========================================================================
  // Transition detectors; bit 8 is the reference input, 7..0 the serial clocks
  assign ext_rise = {external_timing_reference_in, serial_receive_clock} & ~edge_prev;
  assign cav_rise = line_side_cell_available & ~cav_prev;

  // each serial edge held until the next divide-by-16 tick
  // reference edge takes the same path; a new edge beats the clear
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      edge_prev <= '0;
      edge_pend <= '0;
      ext_event <= '0;
      cav_prev <= '0;
    end
    else
    begin
      edge_prev <= {external_timing_reference_in, serial_receive_clock};
      edge_pend <= (edge_pend & ~{(NUM_SERIAL + 1){tick16}}) | ext_rise;
      ext_event <= edge_pend & {(NUM_SERIAL + 1){tick16}};
      cav_prev <= line_side_cell_available;
    end
  end

  // ==========================================================================
  // Pre-scaler; at most one output per 16 cycles survives the resync
  assign pre_in = pre_src ? ext_event[NUM_SERIAL] : 1'b1;
  assign pre_sum = {1'b0, pre_acc} + {1'b0, pre_num};

  // fractional divide by numerator over denominator
  // output released on the divide-by-16 tick
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pre_acc <= 16'h0000;
      pre_pend <= 1'b0;
      pre_event <= 1'b0;
    end
    else
    begin
      pre_event <= pre_pend & tick16;
      if (pre_den != 16'h0000 && pre_in && pre_sum >= {1'b0, pre_den})
      begin
        pre_acc <= 16'(pre_sum - {1'b0, pre_den});
        pre_pend <= 1'b1;
      end
      else
      begin
        if (pre_den != 16'h0000 && pre_in)
          pre_acc <= pre_sum[15:0];
        pre_pend <= pre_pend & ~tick16;
      end
    end
  end

  // ==========================================================================
  // Rate channels: 0..15 transmit groups, 16..31 receive groups
  // thirty-two independent channels
  for (genvar c = 0; c < NUM_CHANS; c++)
  begin : g_ch
    chan_if chans ();
    assign chans.enable = chan_cfg[c][CFG_EN_BIT];
    assign chans.src = clk_src_t'(chan_cfg[c][CFG_SRC_LSB +: 2]);
    assign chans.inc = chan_inc[c][15:0];
    assign chans.bits_per_cell = chan_div[c][15:0];
    // source mux; per channel; cell-available; any serial clock
    assign chans.src_event = pick_event(chans.src, tick24, pre_event, ext_event[NUM_SERIAL-1:0],
                                        chan_cfg[c][CFG_SER_LSB +: 3], tick16);
    // any of the 32 ports as lock reference
    assign chans.lock_event = cav_rise[chan_cfg[c][CFG_PORT_LSB +: 5]];
    assign cell_ticks[c] = chans.cell_tick;
    cell_rate_channel u_chan (
      .clk(clk),
      .nrst(nrst),
      .ch(chans)
    );
  end

  // transmit outputs pace framing; one per group
  // receive outputs drive the smoothing buffer
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      transmit_cell_rate_clock <= '0;
      receive_cell_rate_clock <= '0;
    end
    else
    begin
      transmit_cell_rate_clock <= cell_ticks[NUM_GROUPS-1:0];
      receive_cell_rate_clock <= cell_ticks[NUM_CHANS-1:NUM_GROUPS];
    end
  end

  // ==========================================================================
  // Timing reference outputs; cfg bit 2i picks 8 kHz, bit 2i+1 locks to reference
  // pass-through or generated 8 kHz locked to the chosen timing source
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < NUM_TREF; i++)
        tref_cnt[i] <= 16'h0000;
      tref_gen <= '0;
      timing_reference_output <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_TREF; i++)
      begin
        if (tref_cfg[2*i+1] ? ext_event[NUM_SERIAL] : 1'b1)
        begin
          if (tref_cnt[i] + 16'h0001 >= (tref_cfg[2*i+1] ? tref_div[16*i +: 16] : TREF_HALF_CYCLES))
          begin
            tref_cnt[i] <= 16'h0000;
            tref_gen[i] <= ~tref_gen[i];
          end
          else
            tref_cnt[i] <= tref_cnt[i] + 16'h0001;
        end
        timing_reference_output[i] <= tref_cfg[2*i] ? tref_gen[i] : edge_prev[NUM_SERIAL];
      end
    end
  end

  // ==========================================================================
  // Register port
  assign ch_idx = reg_addr[8:4];
  assign status_rd = reg_read && reg_addr == OFF_STATUS;

  // channels reset disabled; software writes the source select
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < NUM_CHANS; i++)
      begin
        chan_cfg[i] <= RST_WORD;
        chan_inc[i] <= RST_WORD;
        chan_div[i] <= RST_WORD;
      end
      pre_num <= 16'h0000;
      pre_den <= 16'h0000;
      pre_src <= 1'b0;
      tref_cfg <= 4'h0;
      tref_div <= RST_WORD;
    end
    else if (reg_write)
    begin
      if (chan_hit(reg_addr) && reg_addr[3:2] == WORD_CHAN_CFG)
        chan_cfg[ch_idx] <= {19'h00000, reg_wdata[12:8], 1'b0, reg_wdata[6:0]};
      else if (chan_hit(reg_addr) && reg_addr[3:2] == WORD_CHAN_INC)
        chan_inc[ch_idx] <= {16'h0000, reg_wdata[15:0]};
      else if (chan_hit(reg_addr) && reg_addr[3:2] == WORD_CHAN_DIV)
        chan_div[ch_idx] <= {16'h0000, reg_wdata[15:0]};
      else if (reg_addr == OFF_PRE_NUM)
        pre_num <= reg_wdata[15:0];
      else if (reg_addr == OFF_PRE_DEN)
        pre_den <= reg_wdata[15:0];
      else if (reg_addr == OFF_PRE_SRC)
        pre_src <= reg_wdata[0];
      else if (reg_addr == OFF_TREF_CFG)
        tref_cfg <= reg_wdata[3:0];
      else if (reg_addr == OFF_TREF_DIV)
        tref_div <= reg_wdata;
    end
  end

  // Activity flags: a tick in the clearing read cycle stays set
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      status_flags <= '0;
    else
      status_flags <= (status_rd ? '0 : status_flags) | cell_ticks;
  end

  // Read data valid only in the cycle after the read strobe
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= RST_WORD;
    else if (!reg_read)
      reg_rdata <= RST_WORD;
    else if (chan_hit(reg_addr) && reg_addr[3:2] == WORD_CHAN_CFG)
      reg_rdata <= chan_cfg[ch_idx];
    else if (chan_hit(reg_addr) && reg_addr[3:2] == WORD_CHAN_INC)
      reg_rdata <= chan_inc[ch_idx];
    else if (chan_hit(reg_addr) && reg_addr[3:2] == WORD_CHAN_DIV)
      reg_rdata <= chan_div[ch_idx];
    else if (reg_addr == OFF_PRE_NUM)
      reg_rdata <= {16'h0000, pre_num};
    else if (reg_addr == OFF_PRE_DEN)
      reg_rdata <= {16'h0000, pre_den};
    else if (reg_addr == OFF_PRE_SRC)
      reg_rdata <= {31'h00000000, pre_src};
    else if (reg_addr == OFF_TREF_CFG)
      reg_rdata <= {28'h0000000, tref_cfg};
    else if (reg_addr == OFF_TREF_DIV)
      reg_rdata <= tref_div;
    else if (status_rd)
      reg_rdata <= status_flags;
    else
      reg_rdata <= RST_WORD;
  end

  // ==========================================================================
  // Checks
  AST_DIV16_PERIOD: assert property (@(posedge clk) disable iff (!nrst)
    tick16 |-> ##16 tick16) else $error("divide-by-16 period wrong");
  AST_DIV24_PERIOD: assert property (@(posedge clk) disable iff (!nrst)
    tick24 |=> !tick24 [*8] ##16 tick24) else $error("divide-by-24 period wrong");
  AST_SER_ON_TICK: assert property (@(posedge clk) disable iff (!nrst)
    (|ext_event) |-> $past(tick16)) else $error("serial event off the sync tick");
  AST_REF_DELIVER: assert property (@(posedge clk) disable iff (!nrst)
    ext_rise[NUM_SERIAL] |-> ##[1:17] ext_event[NUM_SERIAL]) else $error("reference edge lost");
  AST_PRE_ON_TICK: assert property (@(posedge clk) disable iff (!nrst)
    pre_event |-> $past(tick16) && $past(pre_pend)) else $error("pre-scaler output not resynced");
  AST_LINE_TOGGLE: assert property (@(posedge clk) disable iff (!nrst)
    1'b1 |=> line_side_receive_clock != $past(line_side_receive_clock)) else $error("line clock stuck");
  AST_TX_PACE: assert property (@(posedge clk) disable iff (!nrst)
    cell_ticks[0] |=> transmit_cell_rate_clock[0] && status_flags[0]) else $error("transmit cell clock lost");
  AST_TREF_PASS: assert property (@(posedge clk) disable iff (!nrst)
    (!tref_cfg[0] && $stable(tref_cfg)) |=> timing_reference_output[0] == $past(edge_prev[NUM_SERIAL]))
    else $error("reference pass-through wrong");

  COV_TX_TICK: cover property (@(posedge clk) disable iff (!nrst) transmit_cell_rate_clock[0]);
  COV_RX_TICK: cover property (@(posedge clk) disable iff (!nrst) receive_cell_rate_clock[0]);
  COV_TREF_GEN: cover property (@(posedge clk) disable iff (!nrst) tref_cfg[0] && $rose(tref_gen[0]));
  COV_STATUS_RD: cover property (@(posedge clk) disable iff (!nrst) status_rd && status_flags != '0);
endmodule

// ### cellclk_pkg.sv
// Constants, register map and types for the cell-rate clock generator
package cellclk_pkg;

  // ==========================================================================
  // Structure
  localparam int NUM_GROUPS = 16;
  localparam int NUM_CHANS = 32;
  localparam int NUM_SERIAL = 8;
  localparam int NUM_PORTS = 32;
  localparam int NUM_TREF = 2;
  localparam int ADDR_W = 12;

  // ==========================================================================
  // Clock rates and divider counts
  localparam int CLK_HZ = 40_000_000;
  localparam int TREF_HZ = 8000;
  localparam logic [15:0] TREF_HALF_CYCLES = 16'(CLK_HZ / (2 * TREF_HZ));
  localparam logic [3:0] DIV16_LAST = 4'hF;
  localparam logic [4:0] DIV24_LAST = 5'h17;
  localparam logic [10:0] STUFF_LAST_CELL = 11'h7FF;

  // ==========================================================================
  // Register map (byte addresses); channel c lives at c*16, word in addr[3:2]
  localparam logic [1:0] WORD_CHAN_CFG = 2'h0;
  localparam logic [1:0] WORD_CHAN_INC = 2'h1;
  localparam logic [1:0] WORD_CHAN_DIV = 2'h2;
  localparam logic [ADDR_W-1:0] OFF_PRE_NUM = 12'h400;
  localparam logic [ADDR_W-1:0] OFF_PRE_DEN = 12'h404;
  localparam logic [ADDR_W-1:0] OFF_PRE_SRC = 12'h408;
  localparam logic [ADDR_W-1:0] OFF_TREF_CFG = 12'h40C;
  localparam logic [ADDR_W-1:0] OFF_TREF_DIV = 12'h410;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h414;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // Channel config fields
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_SRC_LSB = 1;
  localparam int CFG_SER_LSB = 4;
  localparam int CFG_PORT_LSB = 8;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {SRC_SYS24, SRC_PRESCALE, SRC_SERIAL, SRC_CELLAV} clk_src_t;
  typedef enum logic {CH_IDLE, CH_RUN} ch_state_t;

endpackage

// ### chan_if.sv
// Per-channel settings and events between the top and one rate channel
`timescale 1ns/10ps
interface chan_if;
  import cellclk_pkg::*;
  logic enable;
  clk_src_t src;
  logic [15:0] inc;
  logic [15:0] bits_per_cell;
  logic src_event;
  logic lock_event;
  logic cell_tick;

  modport ctl (output enable, src, inc, bits_per_cell, src_event, lock_event, input cell_tick);
  modport chan (input enable, src, inc, bits_per_cell, src_event, lock_event, output cell_tick);
endinterface

// ### cell_rate_channel.sv
// One rate channel: bit-rate oscillator, cell divider with stuffing, DPLL trim
`timescale 1ns/10ps
module cell_rate_channel (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Settings and events
  chan_if.chan ch
);
  import cellclk_pkg::*;

  ch_state_t state;
  logic [15:0] acc;
  logic [15:0] trim;
  logic bit_tick;
  logic [15:0] bit_cnt;
  logic [10:0] cell_cnt;
  logic stuff;
  logic signed [7:0] err;
  logic [16:0] nco_sum;
  logic [15:0] last_bit;
  logic slot;

  // ==========================================================================
  // Oscillator sum; an increment of all ones gives one bit per source event
  assign nco_sum = {1'b0, acc} + {1'b0, trim} + 17'h00001;
  assign last_bit = (ch.bits_per_cell == 16'h0000) ? 16'h0000 : ch.bits_per_cell - 16'h0001;
  assign slot = bit_tick && (bit_cnt >= last_bit);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state <= CH_IDLE;
    else
      state <= ch.enable ? CH_RUN : CH_IDLE;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      acc <= 16'h0000;
      bit_tick <= 1'b0;
    end
    else if (state == CH_IDLE)
    begin
      acc <= 16'h0000;
      bit_tick <= 1'b0;
    end
    else
    begin
      bit_tick <= ch.src_event & nco_sum[16];
      if (ch.src_event)
        acc <= nco_sum[15:0];
    end
  end

  // bits-per-cell division; skip one slot per 2048 cells
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bit_cnt <= 16'h0000;
      cell_cnt <= 11'h000;
      stuff <= 1'b0;
    end
    else if (state == CH_IDLE)
    begin
      bit_cnt <= 16'h0000;
      cell_cnt <= 11'h000;
      stuff <= 1'b0;
    end
    else if (slot)
    begin
      bit_cnt <= 16'h0000;
      if (stuff)
        stuff <= 1'b0;
      else
      begin
        cell_cnt <= cell_cnt + 11'h001;
        stuff <= (cell_cnt == STUFF_LAST_CELL);
      end
    end
    else if (bit_tick)
      bit_cnt <= bit_cnt + 16'h0001;
  end

  // no cell clock while disabled, checked against the live enable
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ch.cell_tick <= 1'b0;
    else
      ch.cell_tick <= ch.enable && (state == CH_RUN) && slot && !stuff;
  end

  // frequency trim against the selected cell-available port
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      trim <= 16'h0000;
      err <= 8'sh00;
    end
    else if (state == CH_IDLE)
    begin
      trim <= ch.inc;
      err <= 8'sh00;
    end
    else if (ch.src == SRC_CELLAV)
    begin
      if (ch.cell_tick && !ch.lock_event && err != 8'sh7F)
        err <= err + 8'sh01;
      else if (ch.lock_event && !ch.cell_tick && err != -8'sh7F)
        err <= err - 8'sh01;
      if (ch.lock_event && err > 8'sh00 && trim != 16'h0000)
        trim <= trim - 16'h0001;
      else if (ch.lock_event && err < 8'sh00 && trim != 16'hFFFF)
        trim <= trim + 16'h0001;
    end
  end

  // ==========================================================================
  // Checks
  AST_IDLE_QUIET: assert property (@(posedge clk) disable iff (!nrst)
    !ch.enable |=> !ch.cell_tick) else $error("cell clock while disabled");
  AST_CELL_FROM_BIT: assert property (@(posedge clk) disable iff (!nrst)
    ch.cell_tick |-> $past(bit_tick)) else $error("cell clock without bit clock");
  AST_STUFF_SKIP: assert property (@(posedge clk) disable iff (!nrst)
    (slot && stuff) |=> !ch.cell_tick) else $error("stuff slot not skipped");
  AST_BIT_FROM_SRC: assert property (@(posedge clk) disable iff (!nrst)
    bit_tick |-> $past(ch.src_event)) else $error("bit clock without source event");
  AST_DPLL_TRIM: assert property (@(posedge clk) disable iff (!nrst)
    (state == CH_RUN && ch.src == SRC_CELLAV && ch.lock_event && err > 8'sh00 && trim != 16'h0000)
    |=> trim == $past(trim) - 16'h0001) else $error("fast oscillator not trimmed down");
endmodule

// ### cell_sink.sv
// Engine-side model that takes the cell-rate pulses of every group
`timescale 1ns/10ps
module cell_sink (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Cell-rate pulses from the generator
  input wire logic [cellclk_pkg::NUM_GROUPS-1:0] tx_cell,
  input wire logic [cellclk_pkg::NUM_GROUPS-1:0] rx_cell,
  // Totals taken by framing and smoothing
  output int tx_total,
  output int rx_total
);
  import cellclk_pkg::*;
  // ==========================================================================
  // Frame pacing and smoothing buffer reads
  // Every high cycle is one cell slot, so a stretched pulse shows as extra cells
  // cell pacing
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_total <= 0;
      rx_total <= 0;
    end
    else
    begin
      tx_total <= tx_total + $countones(tx_cell);
      rx_total <= rx_total + $countones(rx_cell);
    end
  end
endmodule

// ### ima_cell_rate_clock_gen_test.sv
// Self-checking bench for the cell-rate clock generator
`timescale 1ns/10ps
module ima_cell_rate_clock_gen_test;
  import cellclk_pkg::*;
  logic clk, nrst, reg_write, reg_read, ext_ref;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [NUM_SERIAL-1:0] ser;
  logic [NUM_PORTS-1:0] cav;
  logic [NUM_GROUPS-1:0] txc, rxc;
  logic [NUM_TREF-1:0] tref;
  logic lrx, ltx, a;
  int miscompares = 0, checks_done = 0, tx_total, rx_total, cyc = 0, gap;

  ima_cell_rate_clock_gen uut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .external_timing_reference_in(ext_ref),
    .serial_receive_clock(ser), .line_side_cell_available(cav), .transmit_cell_rate_clock(txc),
    .receive_cell_rate_clock(rxc), .timing_reference_output(tref), .line_side_receive_clock(lrx),
    .line_side_transmit_clock(ltx));
  cell_sink sink (.clk(clk), .nrst(nrst), .tx_cell(txc), .rx_cell(rxc), .tx_total(tx_total),
    .rx_total(rx_total));

  // ==========================================================================
  // Clock, cycle count and a slow serial bit clock well under the /16 sync rate
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
    cyc <= cyc + 1;
  // Serial clock rises every 64 cycles, line-side activity every 128
  assign ser = {7'h00, cyc[5]};
  assign cav = {31'h00000000, cyc[6]};
  assign ext_ref = cyc[4];

  // ==========================================================================
  // Shared compare, bus and timing tasks
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [ADDR_W-1:0] ad, input logic [31:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rdr(input logic [ADDR_W-1:0] ad);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  // Edges until group 0 pulses again; bounded so a dead clock cannot hang
  task pulse_gap(input logic rx_side);
    gap = 0;
    @(posedge clk);
    while ((rx_side ? rxc[0] : txc[0]) !== 1'b1 && gap < 300)
    begin
      @(posedge clk);
      gap++;
    end
  endtask

  // ==========================================================================
  // Scenarios
  task test_reset;
    chk("outputs in reset", 32'h0, {txc, rxc}); // quiet
    @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    a = lrx;
    @(posedge clk);
    chk("line clock toggles", {31'h0, ~a}, {31'h0, lrx}); // line clocks
    chk("line clocks agree", {31'h0, lrx}, {31'h0, ltx}); // line clocks
    rdr(12'h000);
    chk("cfg reset", RST_WORD, rd); // idle after reset
    wr(12'h00C, 32'hFFFF_FFFF);
    rdr(12'h00C);
    chk("unmapped", 32'h0, rd);
    $display("test reset done");
  endtask
  // Every source code must be held by the selector of a disabled channel
  task test_src_codes;
    wr(12'h050, 32'hFFFF_FFFE);
    rdr(12'h050);
    chk("cfg fields", 32'h0000_1F7E, rd); // source mux
    for (int s = 0; s < 4; s++)
    begin
      wr(12'h050, 32'(s) << CFG_SRC_LSB);
      rdr(12'h050);
      chk("source code", 32'(s) << CFG_SRC_LSB, rd); // four sources
    end
    wr(12'h050, 32'h0);
    $display("test source codes done");
  endtask
  task test_sys24;
    wr(12'h004, 32'h0000_FFFF);
    wr(12'h008, 32'h0000_0002);
    wr(12'h000, 32'h0000_0001);
    pulse_gap(1'b0);
    pulse_gap(1'b0);
    chk("tx cell period", 32'd47, 32'(gap)); // sys div 24
    chk("rx idle", 32'h0, {16'h0, rxc}); // independent groups
    $display("test sys24 done");
  endtask
  task test_serial;
    wr(12'h104, 32'h0000_FFFF);
    wr(12'h108, 32'h0000_0001);
    wr(12'h100, 32'h0000_0005);
    pulse_gap(1'b1);
    chk("rx cell seen", 32'h1, {31'h0, rxc[0]}); // serial source
    // The sink counts the pulse at this edge, so look one edge later
    @(posedge clk);
    chk("sink rx", 32'h1, {31'h0, rx_total > 0}); // smoothing pace
    $display("test serial done");
  endtask
  // Pre-scaler at one over one from the system clock: one bit per sync tick
  task test_prescale;
    wr(OFF_PRE_NUM, 32'h1);
    wr(OFF_PRE_DEN, 32'h1);
    wr(12'h000, 32'h0);
    wr(12'h000, 32'h0000_0003);
    pulse_gap(1'b0);
    pulse_gap(1'b0);
    chk("prescaled cell period", 32'd31, 32'(gap)); // prescaler source
    $display("test prescale done");
  endtask
  // Receive group 0 follows line-side port 0 through the trimmed oscillator
  task test_dpll;
    wr(12'h100, 32'h0000_0007);
    repeat (300) @(posedge clk);
    pulse_gap(1'b1);
    chk("dpll rx cell", 32'h1, {31'h0, rxc[0]}); // cell-available source
    $display("test dpll done");
  endtask
  task test_status;
    wr(12'h000, 32'h0);
    wr(12'h100, 32'h0);
    repeat (10) @(posedge clk);
    rdr(OFF_STATUS);
    chk("status seen", 32'h0001_0001, rd); // per group ticks
    rdr(OFF_STATUS);
    chk("status cleared", 32'h0, rd);
    gap = tx_total + rx_total;
    repeat (100) @(posedge clk);
    chk("quiet when off", 32'(gap), 32'(tx_total + rx_total)); // disabled
    $display("test status done");
  endtask
  task test_tref;
    wr(OFF_TREF_CFG, 32'h1);
    // Let the switch from pass-through settle so only real toggles are timed
    repeat (2) @(posedge clk);
    a = tref[0];
    gap = 0;
    while (tref[0] === a && gap < 3000)
    begin
      @(posedge clk);
      gap++;
    end
    a = tref[0];
    gap = 0;
    @(posedge clk);
    while (tref[0] === a && gap < 3000)
    begin
      @(posedge clk);
      gap++;
    end
    chk("8 kHz half period", 32'(TREF_HALF_CYCLES) - 32'd1, 32'(gap)); // generated ref
    $display("test tref done");
  endtask

  // ==========================================================================
  // Verdict, watchdog and main sequence
  task finish_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Tests need under 10000 cycles, twice that means a hang
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test;
  end
  initial
  begin
    nrst = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    repeat (12) @(posedge clk);
    test_reset;
    test_src_codes;
    test_sys24;
    test_prescale;
    test_serial;
    test_dpll;
    test_status;
    test_tref;
    finish_test;
  end
endmodule
